// ### hw/plcp_frame_supervisor.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module plcp_frame_supervisor #(
    parameter logic [plcp_frame_pkg::OOF_TIMER_W-1:0] OOF_TIMER_CYCLES =
        plcp_frame_pkg::OOF_TIMER_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [plcp_frame_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // receive line events
    input wire logic pair_strobe,
    input wire logic [7:0] framing_octet_one,
    input wire logic [7:0] framing_octet_two,
    input wire logic row_strobe,
    input wire logic [7:0] row_id,
    input wire logic code_strobe,
    input wire logic [2:0] link_status_code,
    input wire logic jam_match,
    // dqdb layer side
    input wire logic head_operation,
    input wire logic ext_timing_select,
    output logic link_status_indication,
    output logic octet_indication_valid,
    output logic management_valid,
    // transmit control
    output logic tx_framed,
    output logic tx_frame_start,
    output logic tx_timing_external,
    output logic [2:0] tx_code_opposite_bus,
    output logic tx_down_same_bus
);
    typedef struct packed {
        plcp_frame_pkg::frame_state_t state;
        logic [plcp_frame_pkg::OOF_TIMER_W-1:0] timer;
        logic [plcp_frame_pkg::JAM_CNT_W-1:0] jam_cnt;
        logic pair_good;
        logic [5:0] last_row;
        logic last_ok;
        logic [1:0] good_run;
        logic [1:0] bad_run;
        logic mgmt_seen;
        logic link_up;
        logic [2:0] rx_code;
        logic [2:0] tx_code;
        logic framed;
        logic frame_start;
        logic timing_ext;
        logic same_bus_down;
        logic head_capable_flag;
        logic forced_down_control;
        logic [31:0] rdata;
    } frame_regs_t;

    frame_regs_t q;
    frame_regs_t d;

    // row_id octet: number in range, reserved bit clear, odd parity
    function automatic logic row_ok(input logic [7:0] oct);
        row_ok = (oct[7:plcp_frame_pkg::ROW_NUM_LSB] <= plcp_frame_pkg::ROW_ID_MAX) &&
                 !oct[plcp_frame_pkg::ROW_RSV_BIT] && (^oct);
    endfunction : row_ok

    // rows count down from the top number to zero, then wrap
    function automatic logic [5:0] next_row(input logic [5:0] num);
        next_row = (num == 6'h00) ? plcp_frame_pkg::ROW_ID_MAX : num - 6'h01;
    endfunction : next_row

    function automatic logic code_known(input logic [2:0] c);
        code_known = (c == plcp_frame_pkg::CODE_CONNECTED) ||
                     (c == plcp_frame_pkg::CODE_LINK_DOWN) ||
                     (c == plcp_frame_pkg::CODE_LINK_UP);
    endfunction : code_known

    // qualified framing events from the current row
    logic row_valid;
    logic row_seq;
    logic row_good;
    logic acquire_two;
    logic acquire_one;
    logic pair_both_bad;
    logic timer_expired;
    logic jam_seen;
    assign row_valid = row_strobe && row_ok(row_id);
    assign row_seq = q.last_ok && (row_id[7:2] == next_row(q.last_row));
    assign row_good = row_valid && q.pair_good;
    assign acquire_two = row_good && row_seq && (q.good_run != 2'h0);
    assign acquire_one = row_good;
    assign pair_both_bad = pair_strobe && (framing_octet_one != plcp_frame_pkg::FRAMING_ONE) &&
                           (framing_octet_two != plcp_frame_pkg::FRAMING_TWO);
    assign timer_expired = (q.timer == OOF_TIMER_CYCLES - 1'b1);
    assign jam_seen = (q.jam_cnt >= plcp_frame_pkg::JAM_CYCLES);

    // next state of everything
    always_comb begin
        logic loss;
        logic in_oof;
        loss = 1'b0;
        in_oof = 1'b0;
        d = q;
        d.frame_start = 1'b0;
        d.rdata = 32'h0;

        // jam detector, saturating, cleared by any mismatch
        if (!jam_match) begin
            d.jam_cnt = '0;
        end else if (!jam_seen) begin
            d.jam_cnt = q.jam_cnt + 1'b1;
        end

        // framing pair quality held until its row_id arrives
        if (pair_strobe) begin
            d.pair_good = (framing_octet_one == plcp_frame_pkg::FRAMING_ONE) &&
                          (framing_octet_two == plcp_frame_pkg::FRAMING_TWO);
        end

        // row_id run counters
        if (row_strobe) begin
            d.last_ok = row_valid;
            d.last_row = row_id[7:2];
            if (!row_good) begin
                d.good_run = 2'h0;
            end else if (row_seq && q.good_run != 2'h2) begin
                d.good_run = q.good_run + 2'h1;
            end else if (!row_seq) begin
                d.good_run = 2'h1;
            end
            if (row_valid && (row_seq || !q.last_ok)) begin
                d.bad_run = 2'h0;
            end else if (q.bad_run != 2'h2) begin
                d.bad_run = q.bad_run + 2'h1;
            end
        end

        // incoming status code, unknown values dropped
        if (code_strobe && code_known(link_status_code)) begin
            d.rx_code = link_status_code;
        end

        // timer runs only in the out-of-frame states
        in_oof = (q.state == plcp_frame_pkg::ST_OUT_OF_FRAME) ||
                 (q.state == plcp_frame_pkg::ST_OOF_JAM);
        if (in_oof) begin
            d.timer = q.timer + 1'b1;
        end

        // framing state machine; found framing wins over a same-cycle expiry
        case (q.state)
            plcp_frame_pkg::ST_IN_FRAME: begin
                loss = pair_both_bad ||
                       (row_strobe && q.bad_run == 2'h1 && !(row_valid && row_seq));
                if (loss) begin
                    d.state = plcp_frame_pkg::ST_OUT_OF_FRAME;
                    d.timer = '0;
                end else if (row_valid && row_id[7:2] == plcp_frame_pkg::ROW_ID_MGMT) begin
                    d.mgmt_seen = 1'b1;
                end
            end
            plcp_frame_pkg::ST_OUT_OF_FRAME: begin
                if (acquire_two) begin
                    d.state = plcp_frame_pkg::ST_IN_FRAME;
                    d.timer = '0;
                end else if (timer_expired) begin
                    d.state = plcp_frame_pkg::ST_LOSS_OF_FRAME;
                end else if (jam_seen) begin
                    d.state = plcp_frame_pkg::ST_OOF_JAM;
                    d.timer = '0;
                end
            end
            plcp_frame_pkg::ST_OOF_JAM: begin
                if (acquire_one) begin
                    d.state = plcp_frame_pkg::ST_IN_FRAME;
                    d.timer = '0;
                end else if (timer_expired) begin
                    d.state = plcp_frame_pkg::ST_LOSS_OF_FRAME;
                end
            end
            plcp_frame_pkg::ST_LOSS_OF_FRAME: begin
                if (acquire_two) begin
                    d.state = plcp_frame_pkg::ST_IN_FRAME;
                end
            end
            default: begin
                d.state = plcp_frame_pkg::ST_LOSS_OF_FRAME;
            end
        endcase
        if (d.state != plcp_frame_pkg::ST_IN_FRAME) begin
            d.mgmt_seen = 1'b0;
        end
        // a fresh lock forgets row errors seen while hunting, else one later slip drops it
        if (d.state == plcp_frame_pkg::ST_IN_FRAME &&
            q.state != plcp_frame_pkg::ST_IN_FRAME) begin
            d.bad_run = 2'h0;
        end
        if (d.state != plcp_frame_pkg::ST_OUT_OF_FRAME &&
            d.state != plcp_frame_pkg::ST_OOF_JAM) begin
            d.timer = '0;
        end

        // reported status and outgoing code, aligned with the new state
        if (q.forced_down_control) begin
            d.link_up = 1'b0;
            d.tx_code = plcp_frame_pkg::CODE_LINK_DOWN;
        end else begin
            case (d.state)
                plcp_frame_pkg::ST_IN_FRAME: begin
                    if (q.state == plcp_frame_pkg::ST_LOSS_OF_FRAME) begin
                        d.link_up = 1'b1;
                        d.tx_code = plcp_frame_pkg::CODE_CONNECTED;
                    end else if (q.rx_code == plcp_frame_pkg::CODE_LINK_DOWN) begin
                        d.link_up = 1'b0;
                        d.tx_code = plcp_frame_pkg::CODE_LINK_UP;
                    end else begin
                        d.link_up = 1'b1;
                        d.tx_code = plcp_frame_pkg::CODE_CONNECTED;
                    end
                end
                plcp_frame_pkg::ST_LOSS_OF_FRAME: begin
                    d.link_up = 1'b0;
                    d.tx_code = jam_seen ? plcp_frame_pkg::CODE_LINK_UP :
                                           plcp_frame_pkg::CODE_LINK_DOWN;
                end
                default: begin
                    d.tx_code = plcp_frame_pkg::CODE_LINK_UP;
                end
            endcase
        end

        // node isolation: a non-head-capable node reflects link-down
        d.same_bus_down = !q.head_capable_flag &&
                          (d.rx_code == plcp_frame_pkg::CODE_LINK_DOWN);

        // framed signal or jam on this bus
        case (d.state)
            plcp_frame_pkg::ST_IN_FRAME: d.framed = 1'b1;
            plcp_frame_pkg::ST_LOSS_OF_FRAME: d.framed = q.head_capable_flag;
            default: d.framed = head_operation;
        endcase
        // each framed start begins with a framing pair
        d.frame_start = d.framed && (!q.framed ||
                        (d.state == plcp_frame_pkg::ST_IN_FRAME &&
                         q.state != plcp_frame_pkg::ST_IN_FRAME));
        d.timing_ext = d.framed && d.state != plcp_frame_pkg::ST_IN_FRAME && ext_timing_select;

        // register writes steer head capability and forced-down control
        if (reg_write && reg_addr == plcp_frame_pkg::ADDR_CTRL) begin
            d.head_capable_flag = reg_wdata[plcp_frame_pkg::CTRL_HEAD_CAPABLE];
            d.forced_down_control = reg_wdata[plcp_frame_pkg::CTRL_FORCED_DOWN];
        end

        // read data stand for exactly one cycle; unmapped reads give zero
        if (reg_read && reg_addr == plcp_frame_pkg::ADDR_CTRL) begin
            d.rdata[plcp_frame_pkg::CTRL_HEAD_CAPABLE] = q.head_capable_flag;
            d.rdata[plcp_frame_pkg::CTRL_FORCED_DOWN] = q.forced_down_control;
        end else if (reg_read && reg_addr == plcp_frame_pkg::ADDR_STATUS) begin
            d.rdata[plcp_frame_pkg::STAT_STATE_LSB +: 4] = q.state;
            d.rdata[plcp_frame_pkg::STAT_LINK_UP] = q.link_up;
            d.rdata[plcp_frame_pkg::STAT_JAM] = jam_seen;
            d.rdata[plcp_frame_pkg::STAT_MGMT_VALID] = q.mgmt_seen;
            d.rdata[plcp_frame_pkg::STAT_FRAMED] = q.framed;
            d.rdata[plcp_frame_pkg::STAT_CODE_LSB +: 3] = q.rx_code;
        end
    end

    // one register for all state; power-up lands in loss_of_frame
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
            q.state <= plcp_frame_pkg::ST_LOSS_OF_FRAME;
            q.rx_code <= plcp_frame_pkg::CODE_CONNECTED;
            q.tx_code <= plcp_frame_pkg::CODE_LINK_DOWN;
            q.head_capable_flag <= plcp_frame_pkg::CTRL_RESET[plcp_frame_pkg::CTRL_HEAD_CAPABLE];
            q.forced_down_control <= plcp_frame_pkg::CTRL_RESET[plcp_frame_pkg::CTRL_FORCED_DOWN];
        end else begin
            q <= d;
        end
    end

    // outputs straight from the register
    assign reg_rdata = q.rdata;
    assign link_status_indication = q.link_up;
    assign octet_indication_valid = (q.state == plcp_frame_pkg::ST_IN_FRAME);
    assign management_valid = (q.state == plcp_frame_pkg::ST_IN_FRAME) && q.mgmt_seen;
    assign tx_framed = q.framed;
    assign tx_frame_start = q.frame_start;
    assign tx_timing_external = q.timing_ext;
    assign tx_code_opposite_bus = q.tx_code;
    assign tx_down_same_bus = q.same_bus_down;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_reset_lands_lof: assert property (@(posedge clk) disable iff (1'b0)
        !reset_n |=> q.state == plcp_frame_pkg::ST_LOSS_OF_FRAME)
        else $error("reset did not land in loss_of_frame");
    a_oof_two_rows: assert property (
        q.state == plcp_frame_pkg::ST_OUT_OF_FRAME && acquire_two && !q.forced_down_control
        |=> q.state == plcp_frame_pkg::ST_IN_FRAME && q.timer == '0 && octet_indication_valid)
        else $error("out_of_frame did not acquire on two rows");
    a_timer_expiry_lof: assert property (
        (q.state == plcp_frame_pkg::ST_OUT_OF_FRAME || q.state == plcp_frame_pkg::ST_OOF_JAM)
        && timer_expired && !acquire_one |=> q.state == plcp_frame_pkg::ST_LOSS_OF_FRAME)
        else $error("timer expiry did not give loss_of_frame");
    a_jam_entry: assert property (
        q.state == plcp_frame_pkg::ST_OUT_OF_FRAME && jam_seen && !acquire_two && !timer_expired
        |=> q.state == plcp_frame_pkg::ST_OOF_JAM && q.timer == '0)
        else $error("jam did not give out_of_frame_jam");
    a_jam_tx_invalid: assert property (
        q.state == plcp_frame_pkg::ST_OOF_JAM |-> !octet_indication_valid && !management_valid)
        else $error("octets valid while out of frame");
    a_jam_one_row: assert property (
        q.state == plcp_frame_pkg::ST_OOF_JAM && acquire_one
        |=> q.state == plcp_frame_pkg::ST_IN_FRAME)
        else $error("out_of_frame_jam did not acquire on one row");
    a_lof_reports_down: assert property (
        !$past(q.forced_down_control) && $changed(q.state) &&
        q.state == plcp_frame_pkg::ST_LOSS_OF_FRAME
        |-> !link_status_indication &&
            tx_code_opposite_bus == ($past(jam_seen) ? plcp_frame_pkg::CODE_LINK_UP :
                                                plcp_frame_pkg::CODE_LINK_DOWN))
        else $error("loss_of_frame entry did not report down");
    a_lof_framed_sel: assert property (
        q.state == plcp_frame_pkg::ST_LOSS_OF_FRAME && $stable(q.head_capable_flag)
        |-> tx_framed == q.head_capable_flag)
        else $error("loss_of_frame transmit selection wrong");
    a_lof_up_report: assert property (
        q.state == plcp_frame_pkg::ST_LOSS_OF_FRAME && acquire_two && !q.forced_down_control
        |=> link_status_indication && (q.state == plcp_frame_pkg::ST_IN_FRAME))
        else $error("loss_of_frame exit did not report up");
    a_inf_frame_start: assert property (
        $rose(octet_indication_valid) |-> tx_framed && tx_frame_start)
        else $error("in_frame entry without framing start");
    a_mgmt_gate: assert property (
        $rose(octet_indication_valid) |-> !management_valid)
        else $error("management valid too early");
    a_inf_loss: assert property (
        q.state == plcp_frame_pkg::ST_IN_FRAME && pair_both_bad
        |=> q.state == plcp_frame_pkg::ST_OUT_OF_FRAME ##1 q.timer == 1)
        else $error("errored pair did not leave in_frame");
    a_forced_down: assert property (
        q.forced_down_control |=> !link_status_indication &&
        tx_code_opposite_bus == plcp_frame_pkg::CODE_LINK_DOWN)
        else $error("forced down not honoured");
    a_isolate_node: assert property (
        !q.head_capable_flag && d.rx_code == plcp_frame_pkg::CODE_LINK_DOWN |=> tx_down_same_bus)
        else $error("node not isolated on link-down");

    c_acquire_from_lof: cover property (
        q.state == plcp_frame_pkg::ST_LOSS_OF_FRAME ##1 q.state == plcp_frame_pkg::ST_IN_FRAME);
    c_jam_recovery: cover property (
        q.state == plcp_frame_pkg::ST_OOF_JAM ##1 q.state == plcp_frame_pkg::ST_IN_FRAME);
    c_timer_expiry: cover property (
        q.state == plcp_frame_pkg::ST_OUT_OF_FRAME
        ##1 q.state == plcp_frame_pkg::ST_LOSS_OF_FRAME);
endmodule : plcp_frame_supervisor

// ### common/plcp_frame_pkg.sv
package plcp_frame_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int OOF_TIMER_NS = 1000000;
    localparam int JAM_DETECT_NS = 16000;
    localparam int OOF_TIMER_W = 17;
    localparam int JAM_CNT_W = 10;
    localparam logic [OOF_TIMER_W-1:0] OOF_TIMER_CYCLES =
        OOF_TIMER_W'(OOF_TIMER_NS / CLK_PERIOD_NS);
    localparam logic [JAM_CNT_W-1:0] JAM_CYCLES =
        JAM_CNT_W'((JAM_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // link status codes
    localparam logic [2:0] CODE_CONNECTED = 3'h0;
    localparam logic [2:0] CODE_LINK_DOWN = 3'h3;
    localparam logic [2:0] CODE_LINK_UP = 3'h6;

    // framing and row_id octets
    localparam logic [7:0] FRAMING_ONE = 8'hF6;
    localparam logic [7:0] FRAMING_TWO = 8'h28;
    localparam logic [5:0] ROW_ID_MAX = 6'h24;
    localparam logic [5:0] ROW_ID_MGMT = 6'h08;
    localparam int ROW_NUM_LSB = 2;
    localparam int ROW_RSV_BIT = 1;

    // register map
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam int CTRL_HEAD_CAPABLE = 0;
    localparam int CTRL_FORCED_DOWN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_LINK_UP = 4;
    localparam int STAT_JAM = 5;
    localparam int STAT_MGMT_VALID = 6;
    localparam int STAT_FRAMED = 7;
    localparam int STAT_CODE_LSB = 8;

    // framing supervisor states
    typedef enum logic [3:0] {
        ST_IN_FRAME = 4'h1,
        ST_OUT_OF_FRAME = 4'h2,
        ST_OOF_JAM = 4'h4,
        ST_LOSS_OF_FRAME = 4'h8
    } frame_state_t;
endpackage : plcp_frame_pkg

// ### dv/line_source.sv
`timescale 1ns/1ps
module line_source (
    // clock
    input wire logic clk,
    // line events toward the supervisor
    output logic pair_strobe,
    output logic [7:0] framing_octet_one,
    output logic [7:0] framing_octet_two,
    output logic row_strobe,
    output logic [7:0] row_id,
    output logic code_strobe,
    output logic [2:0] link_status_code,
    output logic jam_match
);
    // quiet line at time zero
    initial begin
        {pair_strobe, row_strobe, code_strobe, jam_match} = 4'h0;
        {framing_octet_one, framing_octet_two, row_id} = 24'h0;
        link_status_code = 3'h0;
    end
    // a row is its framing pair, then its row_id; idle data toggle so stale values never match
    task automatic send_row(input logic [5:0] num, input logic pair_ok);
        @(posedge clk);
        pair_strobe <= 1'b1;
        framing_octet_one <= pair_ok ? plcp_frame_pkg::FRAMING_ONE : 8'h00;
        framing_octet_two <= pair_ok ? plcp_frame_pkg::FRAMING_TWO : 8'h00;
        @(posedge clk);
        pair_strobe <= 1'b0;
        framing_octet_one <= ~framing_octet_one;
        framing_octet_two <= ~framing_octet_two;
        row_strobe <= 1'b1;
        row_id <= {num, 1'b0, ~^num}; // odd parity over the octet
        @(posedge clk);
        row_strobe <= 1'b0;
        row_id <= ~row_id;
    endtask : send_row
    // one received status code
    task automatic send_code(input logic [2:0] code);
        @(posedge clk);
        code_strobe <= 1'b1;
        link_status_code <= code;
        @(posedge clk);
        code_strobe <= 1'b0;
        link_status_code <= ~code;
    endtask : send_code
    // jam pattern seen for n cycles, left on until jam_stop
    task automatic jam_hold(input int n);
        @(posedge clk);
        jam_match <= 1'b1;
        repeat (n) @(posedge clk);
        #1;
    endtask : jam_hold
    task automatic jam_stop;
        @(posedge clk);
        jam_match <= 1'b0;
    endtask : jam_stop
endmodule : line_source

// ### dv/plcp_framing_lss_control_test.sv
`timescale 1ns/1ps
module plcp_framing_lss_control_test;
    // short timer keeps the run brief; it must exceed the jam duration
    localparam int OOF = 1000;
    localparam int JAM = int'(plcp_frame_pkg::JAM_CYCLES) + 2;
    localparam logic [2:0] DN = plcp_frame_pkg::CODE_LINK_DOWN;
    localparam logic [2:0] UP = plcp_frame_pkg::CODE_LINK_UP;
    localparam logic [2:0] CON = plcp_frame_pkg::CODE_CONNECTED;
    logic clk, reset_n, reg_write, reg_read, head_operation, ext_timing_select;
    logic [plcp_frame_pkg::ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic pair_strobe, row_strobe, code_strobe, jam_match;
    logic [7:0] framing_octet_one, framing_octet_two, row_id;
    logic [2:0] link_status_code, tx_code_opposite_bus;
    logic link_status_indication, octet_indication_valid, management_valid;
    logic tx_framed, tx_frame_start, tx_timing_external, tx_down_same_bus;
    int miscompares, samples_checked, n;
    plcp_frame_supervisor #(.OOF_TIMER_CYCLES(plcp_frame_pkg::OOF_TIMER_W'(OOF))) dut (
        .clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .pair_strobe, .framing_octet_one, .framing_octet_two, .row_strobe, .row_id,
        .code_strobe, .link_status_code, .jam_match, .head_operation, .ext_timing_select,
        .link_status_indication, .octet_indication_valid, .management_valid, .tx_framed,
        .tx_frame_start, .tx_timing_external, .tx_code_opposite_bus, .tx_down_same_bus);
    line_source u_src (.clk, .pair_strobe, .framing_octet_one, .framing_octet_two,
        .row_strobe, .row_id, .code_strobe, .link_status_code, .jam_match);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : idle
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_rd
    // frame start must pulse exactly once after acquisition
    task automatic wait_start;
        n = 0;
        repeat (4) begin
            #1;
            if (tx_frame_start === 1'b1) n++;
            @(posedge clk);
        end
        #1;
        check(n, 1);
    endtask : wait_start
    task automatic state_is(input logic [3:0] s);
        reg_rd(plcp_frame_pkg::ADDR_STATUS, rd);
        check(rd[3:0], s);
    endtask : state_is
    task automatic code_case(input logic [2:0] c, input logic up, input logic [2:0] tx,
                             input logic dn);
        u_src.send_code(c);
        idle(1);
        check(link_status_indication, up);
        check(tx_code_opposite_bus, tx);
        check(tx_down_same_bus, dn);
    endtask : code_case
    // main sequence
    initial begin
        {reset_n, reg_write, reg_read, head_operation, ext_timing_select} = 5'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        {miscompares, samples_checked} = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        idle(1);
        state_is(4'h8);
        check({link_status_indication, octet_indication_valid, tx_framed}, 3'h0);
        check(tx_code_opposite_bus, plcp_frame_pkg::CODE_LINK_DOWN);
        reg_wr(plcp_frame_pkg::ADDR_CTRL, 32'h1);
        idle(1);
        check(tx_framed, 1'b1);
        reg_rd(plcp_frame_pkg::ADDR_CTRL, rd);
        check(rd, 32'h1);
        reg_rd(4'h8, rd);
        check(rd, 32'h0);
        reg_wr(plcp_frame_pkg::ADDR_CTRL, 32'h0);
        u_src.send_row(6'h24, 1'b1);
        u_src.send_row(6'h23, 1'b1);
        wait_start();
        check({link_status_indication, octet_indication_valid, tx_framed}, 3'h7);
        check(tx_code_opposite_bus, plcp_frame_pkg::CODE_CONNECTED);
        for (int r = 34; r > 8; r--) u_src.send_row(6'(r), 1'b1);
        check(management_valid, 1'b0);
        u_src.send_row(6'h08, 1'b1);
        idle(1);
        check(management_valid, 1'b1);
        code_case(DN, 1'b0, UP, 1'b1);
        code_case(3'h5, 1'b0, UP, 1'b1);
        code_case(UP, 1'b1, CON, 1'b0);
        code_case(CON, 1'b1, CON, 1'b0);
        reg_wr(plcp_frame_pkg::ADDR_CTRL, 32'h2);
        idle(1);
        check({link_status_indication, tx_code_opposite_bus}, 4'h3);
        reg_wr(plcp_frame_pkg::ADDR_CTRL, 32'h0);
        // both framing octets wrong drops the frame
        u_src.send_row(6'h07, 1'b0);
        idle(1);
        check({link_status_indication, octet_indication_valid, tx_framed}, 3'h4);
        check(tx_code_opposite_bus, plcp_frame_pkg::CODE_LINK_UP);
        state_is(4'h2);
        // two good sequential rows relock from out_of_frame, two slipped row_ids drop it
        u_src.send_row(6'h06, 1'b1);
        u_src.send_row(6'h05, 1'b1);
        idle(1);
        state_is(4'h1);
        u_src.send_row(6'h20, 1'b1);
        u_src.send_row(6'h20, 1'b1);
        idle(1);
        state_is(4'h2);
        u_src.jam_hold(JAM);
        state_is(4'h4);
        u_src.jam_stop();
        head_operation <= 1'b1;
        ext_timing_select <= 1'b1;
        idle(2);
        check({tx_framed, tx_timing_external, octet_indication_valid}, 3'h6);
        head_operation <= 1'b0;
        idle(2);
        check(tx_framed, 1'b0);
        u_src.send_row(6'h1E, 1'b1);
        idle(1);
        check(octet_indication_valid, 1'b1);
        state_is(4'h1);
        // timer runs from the drop and must expire near its terminal count
        u_src.send_row(6'h1D, 1'b0);
        idle(OOF - 20);
        check(tx_code_opposite_bus, plcp_frame_pkg::CODE_LINK_UP);
        n = 0;
        while (tx_code_opposite_bus !== plcp_frame_pkg::CODE_LINK_DOWN && n < 40) begin
            idle(1);
            n++;
        end
        check(n < 40, 1'b1);
        state_is(4'h8);
        check(link_status_indication, 1'b0);
        u_src.jam_hold(JAM);
        check(tx_code_opposite_bus, plcp_frame_pkg::CODE_LINK_UP);
        check(tx_framed, 1'b0);
        u_src.jam_stop();
        idle(4);
        print_verdict();
    end
    // hang guard
    initial begin
        #1ms;
        miscompares++;
        print_verdict();
    end
endmodule : plcp_framing_lss_control_test
